// *** swcp_pkg.sv ***
// Purpose: shared constants and types for the single-wire command port
// Assumes: 40 MHz aclk, one transaction at a time on the line
// Notes:   times in ns or ms, cycle counts derived below
package swcp_pkg;
  localparam int unsigned CLK_NS         = 25;
  localparam int unsigned T_BIT_NS       = 200_000;
  localparam int unsigned T_HOST_ONE_NS  = 50_000;
  localparam int unsigned T_HOST_ZERO_NS = 150_000;
  localparam int unsigned T_DEV_ONE_NS   = 50_000;
  localparam int unsigned T_DEV_ZERO_NS  = 150_000;
  localparam int unsigned T_SAMPLE_NS    = 100_000;
  localparam int unsigned T_BREAK_NS     = 190_000;
  localparam int unsigned T_BR_NS        = 40_000;
  localparam int unsigned T_RSP_NS       = 190_000;
  localparam int unsigned T_RSP_TMO_NS   = 320_000;
  localparam int unsigned T_GLITCH_NS    = 1_000_000;
  localparam int unsigned T_SHIP_MS      = 16_000;
  localparam int unsigned CYC_PER_MS     = 1_000_000 / CLK_NS;

  // least time: round up
  function automatic int unsigned cyc_up(input int unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  // longest time: round down, at least one cycle
  function automatic int unsigned cyc_dn(input int unsigned ns);
    return (ns < CLK_NS) ? 1 : ns / CLK_NS;
  endfunction

  localparam logic [6:0] ADDR_CTRL     = 7'h00;
  localparam logic [7:0] CTRL_SHIP     = 8'ha9;
  localparam logic [6:0] ADDR_NVM_EN   = 7'h6e;
  localparam logic [7:0] NVM_EN_KEY    = 8'hdd;
  localparam logic [6:0] ADDR_NVM_LO   = 7'h76;
  localparam logic [6:0] ADDR_NVM_HI   = 7'h7f;
  localparam int unsigned CMD_WR_BIT   = 7;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [4:0] LAST_BIT_RD   = 5'h07;
  localparam logic [4:0] LAST_BIT_WR   = 5'h0f;

  // host registers, byte offsets
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_PAIR      = 4'h8;
  localparam int unsigned CMD_BRK_BIT  = 16;
  localparam int unsigned CMD_PAIR_BIT = 17;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {D_WAIT, D_LOW, D_BRK, D_RSP, D_TX} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_BRKL, H_BRKH, H_TX, H_RXW, H_RXL} host_state_t;
endpackage

// *** swcp_if.sv ***
`timescale 1ns/10ps
// Purpose: open-drain single wire joining device and host
// Assumes: external pull-up, either party pulls low
// Notes:   oe_n low means driving the output level
interface swcp_if;
  logic dev_o;
  logic dev_oe_n;
  logic host_o;
  logic host_oe_n;
  logic line;

  // wired-and with pull-up
  assign line = (dev_oe_n | dev_o) & (host_oe_n | host_o);

  modport device (input line, output dev_o, output dev_oe_n);
  modport host   (input line, output host_o, output host_oe_n);
endinterface

// *** gauge_port.sv ***
`timescale 1ns/10ps
// Purpose: device end of the single-wire command port with power modes
// Assumes: supply_ok, backup_present and ship_enable are aclk-domain levels
// Notes:   register bytes live in flip-flops indexed by the 7-bit address
// Notes on behaviour
// - ship armed by 0xa9 to 0x00 with enable
// - armed, line low 16 s enters ship
// - short highs ignored while ship armed
// - ship halts all until high or supply return
// - glitch wakes; low then sleeps, no re-ship
// - low supply with backup hibernates, keeps bytes
// - nvm writes need 0xdd at 0x6e first
// - host programs 0x76-0x7f one at a time
// - command byte, then store or send byte
// - eight bits, lsb first, return-to-one, slow
// - host breaks first and after response time-out
// - long low on idle bus is break
// - host holds break twice the minimum
// - line high for recovery, then commands accepted
// - bit: low start, data section, high stop
// - unlimited high between received bits
// - read data starts one response time later
// - host breaks before each string of accesses
// - bit 7 write flag, bits 6-0 address
// - host reads 16-bit pair high, low, high
// - open drain: drive low or release
module gauge_port
  import swcp_pkg::*;
#(
  parameter int unsigned BIT_CYC    = cyc_up(T_BIT_NS),
  parameter int unsigned ONE_CYC    = cyc_up(T_DEV_ONE_NS),
  parameter int unsigned ZERO_CYC   = cyc_up(T_DEV_ZERO_NS),
  parameter int unsigned SAMPLE_CYC = cyc_dn(T_SAMPLE_NS),
  parameter int unsigned BREAK_CYC  = cyc_up(T_BREAK_NS),
  parameter int unsigned RSP_CYC    = cyc_up(T_RSP_NS),
  parameter int unsigned GLITCH_CYC = cyc_up(T_GLITCH_NS),
  parameter int unsigned SHIP_CYC   = T_SHIP_MS * CYC_PER_MS
)(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  swcp_if.device          link,
  input  wire logic       ship_enable,
  input  wire logic       supply_ok,
  input  wire logic       backup_present,
  input  wire logic       prog_pulse,
  input  wire logic       gauge_wr_en,
  input  wire logic [6:0] gauge_wr_addr,
  input  wire logic [7:0] gauge_wr_data,
  output logic            ship_armed,
  output logic            ship_mode,
  output logic            sleep_mode,
  output logic            hibernate,
  output logic            nvm_prog_enabled,
  output logic            nvm_burn
);
  typedef struct packed {
    logic [2:0]        sync;
    logic              lvl;
    logic              lvl_d;
    dev_state_t        st;
    logic [31:0]       tmr;
    logic [2:0]        nbit;
    logic [7:0]        sh;
    logic              data_ph;
    logic [6:0]        addr;
    logic [127:0][7:0] mem;
    logic [31:0]       low_cnt;
    logic [31:0]       hi_cnt;
    logic              armed;
    logic              ship;
    logic              sleep;
    logic              hib;
    logic              prog_en;
    logic              burn;
    logic              supply_q;
    logic              drv;
    logic              oe_n;
  } dev_t;

  dev_t st_ff;
  dev_t nxt_st;

  function automatic logic is_nvm(input logic [6:0] a);
    return (a >= ADDR_NVM_LO) && (a <= ADDR_NVM_HI);
  endfunction

  always_comb begin
    logic bit_v;
    logic fall;
    logic rise;
    bit_v  = 1'b0;
    nxt_st = st_ff;
    fall   = st_ff.lvl_d & ~st_ff.lvl;
    rise   = ~st_ff.lvl_d & st_ff.lvl;
    nxt_st.sync  = {st_ff.sync[1:0], link.line};
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.lvl = st_ff.sync[2];
    end
    nxt_st.lvl_d    = st_ff.lvl;
    nxt_st.supply_q = supply_ok;
    nxt_st.burn     = 1'b0;
    nxt_st.hib      = ~supply_ok & backup_present;
    if (!supply_ok) begin
      // halted; without backup the bytes are lost
      if (!backup_present) begin
        nxt_st.mem     = '0;
        nxt_st.armed   = 1'b0;
        nxt_st.ship    = 1'b0;
        nxt_st.sleep   = 1'b0;
        nxt_st.prog_en = 1'b0;
      end
      nxt_st.st      = D_WAIT;
      nxt_st.low_cnt = '0;
      nxt_st.hi_cnt  = '0;
    end else if (!st_ff.supply_q) begin
      nxt_st.ship = 1'b0;  // supply return ends ship
    end else if (st_ff.ship) begin
      nxt_st.st = D_WAIT;  // everything stopped
      if (st_ff.lvl) begin
        nxt_st.ship    = 1'b0;  // any high, even a glitch, wakes
        nxt_st.low_cnt = '0;
        nxt_st.hi_cnt  = '0;
      end
    end else begin
      // low-line timing for ship and sleep
      if (!st_ff.lvl) begin
        nxt_st.hi_cnt = '0;
        if (st_ff.low_cnt < SHIP_CYC) begin
          nxt_st.low_cnt = st_ff.low_cnt + 32'h1;
        end else if (st_ff.armed) begin
          nxt_st.ship    = 1'b1;
          nxt_st.armed   = 1'b0;  // fresh command needed next time
          nxt_st.low_cnt = '0;
        end else begin
          nxt_st.sleep = 1'b1;
        end
      end else begin
        nxt_st.sleep = 1'b0;
        if (st_ff.hi_cnt < GLITCH_CYC) begin
          nxt_st.hi_cnt = st_ff.hi_cnt + 32'h1;
        end
        if (!st_ff.armed || st_ff.hi_cnt >= GLITCH_CYC) begin
          nxt_st.low_cnt = '0;  // short highs do not restart while armed
        end
      end
      if (gauge_wr_en) begin
        nxt_st.mem[gauge_wr_addr] = gauge_wr_data;
      end
      nxt_st.burn = st_ff.prog_en & prog_pulse;
      case (st_ff.st)
        D_WAIT: begin
          // high may last forever between bits
          if (fall) begin
            nxt_st.st  = D_LOW;
            nxt_st.tmr = '0;
          end
        end
        D_LOW: begin
          nxt_st.tmr = st_ff.tmr + 32'h1;
          if (rise) begin
            bit_v       = (st_ff.tmr < SAMPLE_CYC);  // level at sample point
            nxt_st.sh   = {bit_v, st_ff.sh[7:1]};  // lsb first
            nxt_st.nbit = st_ff.nbit + 3'h1;
            nxt_st.st   = D_WAIT;
            if (st_ff.nbit == LAST_BIT) begin
              if (!st_ff.data_ph) begin
                nxt_st.addr = nxt_st.sh[6:0];
                if (nxt_st.sh[CMD_WR_BIT]) begin
                  nxt_st.data_ph = 1'b1;
                end else begin
                  nxt_st.st  = D_RSP;
                  nxt_st.tmr = '0;
                end
              end else begin
                nxt_st.data_ph = 1'b0;
                if (!is_nvm(st_ff.addr) || st_ff.prog_en) begin
                  nxt_st.mem[st_ff.addr] = nxt_st.sh;
                end
                if (st_ff.addr == ADDR_NVM_EN) begin
                  nxt_st.prog_en = (nxt_st.sh == NVM_EN_KEY);
                end
                if (st_ff.addr == ADDR_CTRL && nxt_st.sh == CTRL_SHIP && ship_enable) begin
                  nxt_st.armed = 1'b1;
                end
              end
            end
          end else if (st_ff.tmr + 32'h1 >= BREAK_CYC) begin
            nxt_st.st      = D_BRK;
            nxt_st.nbit    = '0;
            nxt_st.data_ph = 1'b0;
          end
        end
        D_BRK: begin
          if (st_ff.lvl) begin
            nxt_st.st = D_WAIT;  // ready for a command
          end
        end
        D_RSP: begin
          nxt_st.tmr = st_ff.tmr + 32'h1;
          if (st_ff.tmr + 32'h1 >= RSP_CYC) begin
            nxt_st.st   = D_TX;
            nxt_st.tmr  = '0;
            nxt_st.nbit = '0;
            nxt_st.sh   = st_ff.mem[st_ff.addr];
          end
        end
        D_TX: begin
          // line ignored here, so a break may be missed
          nxt_st.tmr = st_ff.tmr + 32'h1;
          if (st_ff.tmr + 32'h1 >= BIT_CYC) begin
            nxt_st.tmr  = '0;
            nxt_st.sh   = {1'b0, st_ff.sh[7:1]};
            nxt_st.nbit = st_ff.nbit + 3'h1;
            if (st_ff.nbit == LAST_BIT) begin
              nxt_st.st = D_WAIT;
            end
          end
        end
        default: nxt_st.st = D_WAIT;
      endcase
    end
    // drive low for start and data section, else release
    nxt_st.oe_n = ~((nxt_st.st == D_TX) &&
                    (nxt_st.tmr < (nxt_st.sh[0] ? ONE_CYC : ZERO_CYC)));
    nxt_st.drv  = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff          <= '0;
      st_ff.sync     <= 3'h7;
      st_ff.lvl      <= 1'b1;
      st_ff.lvl_d    <= 1'b1;
      st_ff.supply_q <= 1'b1;
      st_ff.oe_n     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.dev_o     = st_ff.drv;
  assign link.dev_oe_n  = st_ff.oe_n;
  assign ship_armed     = st_ff.armed;
  assign ship_mode      = st_ff.ship;
  assign sleep_mode     = st_ff.sleep;
  assign hibernate      = st_ff.hib;
  assign nvm_prog_enabled = st_ff.prog_en;
  assign nvm_burn       = st_ff.burn;
endmodule

// *** host_engine.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
// Purpose: host end of the single-wire link, driven over AXI4-Lite
// Assumes: one access in flight, software follows the nvm sequence
// Notes:   pair mode reads a 16-bit value safely
module host_engine
  import swcp_pkg::*;
#(
  parameter int unsigned BIT_CYC    = cyc_up(T_BIT_NS),
  parameter int unsigned ONE_CYC    = cyc_dn(T_HOST_ONE_NS),
  parameter int unsigned ZERO_CYC   = cyc_up(T_HOST_ZERO_NS),
  parameter int unsigned SAMPLE_CYC = cyc_dn(T_SAMPLE_NS),
  parameter int unsigned HBRK_CYC   = cyc_up(2 * T_BREAK_NS),
  parameter int unsigned BR_CYC     = cyc_up(T_BR_NS),
  parameter int unsigned TMO_CYC    = cyc_dn(T_RSP_TMO_NS)
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  swcp_if.host             link,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic        lvl_d;
    host_state_t st;
    logic [31:0] tmr;
    logic [15:0] sh;
    logic [4:0]  nbit;
    logic [4:0]  last;
    logic        is_rd;
    logic        brk_need;
    logic        tmo;
    logic        busy;
    logic        pair;
    logic [1:0]  step;
    logic [6:0]  addr_lo;
    logic [7:0]  rbyte;
    logic [7:0]  h0;
    logic [7:0]  l0;
    logic [7:0]  h1;
    logic [15:0] result;
    logic        aw_got;
    logic [3:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        drv;
    logic        oe_n;
  } host_t;

  host_t st_ff;
  host_t nxt_st;

  // send a read command byte for address a
  function automatic host_t launch(input host_t s, input logic [6:0] a);
    host_t r;
    r       = s;
    r.sh    = {8'h00, 1'b0, a};
    r.last  = LAST_BIT_RD;
    r.is_rd = 1'b1;
    r.nbit  = '0;
    r.tmr   = '0;
    r.st    = H_TX;
    return r;
  endfunction

  always_comb begin
    logic fall;
    logic rise;
    logic bit_v;
    logic [7:0] byte_v;
    nxt_st = st_ff;
    fall   = st_ff.lvl_d & ~st_ff.lvl;
    rise   = ~st_ff.lvl_d & st_ff.lvl;
    bit_v  = 1'b0;
    byte_v = '0;
    nxt_st.sync = {st_ff.sync[1:0], link.line};
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.lvl = st_ff.sync[2];
    end
    nxt_st.lvl_d = st_ff.lvl;
    // register bus: write
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
      if (st_ff.awaddr == REG_CMD) begin
        if (!st_ff.busy && st_ff.wstrb[2:0] == 3'h7) begin
          nxt_st.busy    = 1'b1;
          nxt_st.tmo     = 1'b0;
          nxt_st.addr_lo = st_ff.wdata[6:0];
          nxt_st.pair    = st_ff.wdata[CMD_PAIR_BIT] & ~st_ff.wdata[CMD_WR_BIT];
          nxt_st.step    = '0;
          nxt_st.sh      = st_ff.wdata[15:0];
          nxt_st.is_rd   = ~st_ff.wdata[CMD_WR_BIT];
          nxt_st.last    = st_ff.wdata[CMD_WR_BIT] ? LAST_BIT_WR : LAST_BIT_RD;
          nxt_st.nbit    = '0;
          nxt_st.tmr     = '0;
          if (nxt_st.pair) begin
            nxt_st = launch(nxt_st, st_ff.wdata[6:0] + 7'h1);  // high byte first
          end
          // break before first access or after a time-out
          if (st_ff.brk_need || st_ff.wdata[CMD_BRK_BIT]) begin
            nxt_st.st = H_BRKL;
          end else begin
            nxt_st.st = H_TX;
          end
        end
      end else if (st_ff.awaddr == REG_STATUS || st_ff.awaddr == REG_PAIR) begin
        nxt_st.bresp = RESP_OKAY;
      end else begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    // register bus: read
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      if (s_axi_araddr == REG_STATUS) begin
        nxt_st.rdata = {16'h0000, st_ff.rbyte, 5'h00, st_ff.brk_need, st_ff.tmo, st_ff.busy};
      end else if (s_axi_araddr == REG_PAIR) begin
        nxt_st.rdata = {16'h0000, st_ff.result};
      end else if (s_axi_araddr == REG_CMD) begin
        nxt_st.rdata = '0;
      end else begin
        nxt_st.rdata = '0;
        nxt_st.rresp = RESP_SLVERR;
      end
    end
    // link engine
    case (st_ff.st)
      H_IDLE: nxt_st.busy = (nxt_st.st != H_IDLE);  // command taken now stays busy
      H_BRKL: begin
        nxt_st.tmr = st_ff.tmr + 32'h1;
        if (st_ff.tmr + 32'h1 >= HBRK_CYC) begin
          nxt_st.st  = H_BRKH;  // twice the least break
          nxt_st.tmr = '0;
        end
      end
      H_BRKH: begin
        nxt_st.tmr = st_ff.tmr + 32'h1;
        if (st_ff.tmr + 32'h1 >= BR_CYC) begin
          nxt_st.st       = H_TX;  // recovery done
          nxt_st.tmr      = '0;
          nxt_st.brk_need = 1'b0;
        end
      end
      H_TX: begin
        nxt_st.tmr = st_ff.tmr + 32'h1;
        if (st_ff.tmr + 32'h1 >= BIT_CYC) begin
          nxt_st.tmr  = '0;
          nxt_st.sh   = {1'b0, st_ff.sh[15:1]};  // lsb first
          nxt_st.nbit = st_ff.nbit + 5'h1;
          if (st_ff.nbit == st_ff.last) begin
            nxt_st.nbit = '0;
            nxt_st.st   = st_ff.is_rd ? H_RXW : H_IDLE;
          end
        end
      end
      H_RXW: begin
        nxt_st.tmr = st_ff.tmr + 32'h1;
        if (fall) begin
          nxt_st.st  = H_RXL;
          nxt_st.tmr = '0;
        end else if (st_ff.tmr >= TMO_CYC) begin
          nxt_st.tmo      = 1'b1;  // no answer in time
          nxt_st.brk_need = 1'b1;
          nxt_st.st       = H_IDLE;
        end
      end
      H_RXL: begin
        nxt_st.tmr = st_ff.tmr + 32'h1;
        byte_v     = st_ff.sh[7:0];
        if (rise && st_ff.nbit <= LAST_BIT_RD) begin
          bit_v          = (st_ff.tmr < SAMPLE_CYC);
          nxt_st.sh[7:0] = {bit_v, st_ff.sh[7:1]};
          nxt_st.nbit    = st_ff.nbit + 5'h1;
          if (st_ff.nbit != LAST_BIT_RD) begin
            nxt_st.st  = H_RXW;
            nxt_st.tmr = '0;
          end
        end else if (st_ff.nbit > LAST_BIT_RD && st_ff.tmr + 32'h1 >= BIT_CYC) begin
          // wait out the device's last bit cycle
          nxt_st.rbyte = byte_v;
          nxt_st.st    = H_IDLE;
          if (st_ff.pair) begin
            // high, low, high, then low again on mismatch
            case (st_ff.step)
              2'h0: begin
                nxt_st.h0 = byte_v;
                nxt_st    = launch(nxt_st, st_ff.addr_lo);
              end
              2'h1: begin
                nxt_st.l0 = byte_v;
                nxt_st    = launch(nxt_st, st_ff.addr_lo + 7'h1);
              end
              2'h2: begin
                nxt_st.h1 = byte_v;
                if (byte_v == st_ff.h0) begin
                  nxt_st.result = {st_ff.h0, st_ff.l0};
                end else begin
                  nxt_st = launch(nxt_st, st_ff.addr_lo);
                end
              end
              default: nxt_st.result = {st_ff.h1, byte_v};
            endcase
            nxt_st.step = st_ff.step + 2'h1;
          end
        end
      end
      default: nxt_st.st = H_IDLE;
    endcase
    // open drain: pull low or release
    nxt_st.oe_n = ~((nxt_st.st == H_BRKL) ||
                    ((nxt_st.st == H_TX) &&
                     (nxt_st.tmr < (nxt_st.sh[0] ? ONE_CYC : ZERO_CYC))));
    nxt_st.drv     = 1'b0;
    nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
    nxt_st.wready  = ~nxt_st.w_got & ~nxt_st.bvalid;
    nxt_st.arready = ~nxt_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff          <= '0;
      st_ff.sync     <= 3'h7;
      st_ff.lvl      <= 1'b1;
      st_ff.lvl_d    <= 1'b1;
      st_ff.brk_need <= 1'b1;
      st_ff.oe_n     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.host_o    = st_ff.drv;
  assign link.host_oe_n = st_ff.oe_n;
  assign s_axi_awready  = st_ff.awready;
  assign s_axi_wready   = st_ff.wready;
  assign s_axi_bvalid   = st_ff.bvalid;
  assign s_axi_bresp    = st_ff.bresp;
  assign s_axi_arready  = st_ff.arready;
  assign s_axi_rvalid   = st_ff.rvalid;
  assign s_axi_rdata    = st_ff.rdata;
  assign s_axi_rresp    = st_ff.rresp;
endmodule

// *** swcp_checker.sv ***
// Purpose: assertions on the shared single wire
// Assumes: shortened bit timing handed on by the bench
// Notes:   counts are aclk cycles
`timescale 1ns/10ps
module swcp_checker #(
  parameter int ONE = 10, ZERO = 30, BIT = 40, HBRK = 76, RSP = 38, TMO = 64
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic host_o,
  input wire logic host_oe_n,
  input wire logic line
);
  logic [7:0] dlo_ff, hlo_ff, hi_ff;
  logic       hlast_ff;

  // low and high run lengths, last driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dlo_ff   <= 8'h00;
      hlo_ff   <= 8'h00;
      hi_ff    <= 8'h00;
      hlast_ff <= 1'b0;
    end else begin
      dlo_ff   <= dev_oe_n ? 8'h00 : dlo_ff + 8'h01;
      hlo_ff   <= host_oe_n ? 8'h00 : hlo_ff + 8'h01;
      hi_ff    <= !line ? 8'h00 : (hi_ff == 8'hff ? hi_ff : hi_ff + 8'h01);
      hlast_ff <= !host_oe_n ? 1'b1 : (!dev_oe_n ? 1'b0 : hlast_ff);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  dev_low_only_a: assert property (!dev_o)
    else $error("device drives wire high");
  host_low_only_a: assert property (!host_o)
    else $error("host drives wire high");
  dev_pulse_a: assert property ($rose(dev_oe_n) |-> dlo_ff == ONE || dlo_ff == ZERO)
    else $error("device start pulse length wrong");
  host_pulse_a: assert property ($rose(host_oe_n) |-> hlo_ff inside {ONE, ZERO, HBRK})
    else $error("host low pulse length wrong");
  dev_stop_a: assert property ($fell(dev_oe_n) |-> hi_ff >= BIT - ZERO)
    else $error("device bit stop section too short");
  rsp_gap_a: assert property ($fell(dev_oe_n) && hlast_ff |-> hi_ff >= RSP && hi_ff < TMO)
    else $error("device answer delay wrong");
  dev_waits_a: assert property ($fell(dev_oe_n) |-> host_oe_n)
    else $error("device starts while host drives");
  host_waits_a: assert property ($fell(host_oe_n) |-> dev_oe_n)
    else $error("host starts while device drives");
  brk_recover_a: assert property ($rose(host_oe_n) && hlo_ff == HBRK |-> line [*8])
    else $error("no recovery high after break");
endmodule

// *** testbench.sv ***
// Purpose: host engine and gauge port joined on one wire
// Assumes: shortened timing parameters
// Notes:   orders and status over AXI4-Lite
`timescale 1ns/10ps
module testbench import swcp_pkg::*;;
  localparam int BIT = 40, ONE = 10, ZERO = 30, SMP = 20, RSP = 38, HBRK = 76, TMO = 64;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        ship_enable = 1'b0, supply_ok = 1'b1, backup_present = 1'b0, prog_pulse = 1'b0;
  logic        ship_armed, ship_mode, sleep_mode, hibernate, nvm_prog_enabled, nvm_burn;
  logic        gauge_wr_en = 1'b0;
  logic [6:0]  gauge_wr_addr = 7'h00;
  logic [7:0]  gauge_wr_data = 8'h00;
  int          fail_count = 0, comparisons = 0;
  swcp_if link_if();
  gauge_port #(.BIT_CYC(BIT), .ONE_CYC(ONE), .ZERO_CYC(ZERO), .SAMPLE_CYC(SMP),
    .BREAK_CYC(38), .RSP_CYC(RSP), .GLITCH_CYC(20), .SHIP_CYC(60)) gauge_port_i (
    .aclk, .aresetn, .link(link_if.device), .ship_enable, .supply_ok, .backup_present,
    .prog_pulse, .gauge_wr_en, .gauge_wr_addr, .gauge_wr_data,
    .ship_armed, .ship_mode, .sleep_mode, .hibernate, .nvm_prog_enabled, .nvm_burn);
  host_engine #(.BIT_CYC(BIT), .ONE_CYC(ONE), .ZERO_CYC(ZERO), .SAMPLE_CYC(SMP),
    .HBRK_CYC(HBRK), .BR_CYC(8), .TMO_CYC(TMO)) host_engine_i (
    .aclk, .aresetn, .link(link_if.host), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  swcp_checker #(.ONE(ONE), .ZERO(ZERO), .BIT(BIT), .HBRK(HBRK), .RSP(RSP), .TMO(TMO))
    swcp_checker_i (.aclk, .aresetn, .dev_o(link_if.dev_o), .dev_oe_n(link_if.dev_oe_n),
    .host_o(link_if.host_o), .host_oe_n(link_if.host_oe_n), .line(link_if.line));

  always #12.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic link(input logic [31:0] c);
    axw(REG_CMD, c, rsp);
    do axr(REG_STATUS, st, rsp); while (st[0] !== 1'b0);
  endtask
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    link({16'h0000, d, w, a});
  endtask
  task automatic stop_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(1'b1, 7'h05, 8'h5a);
    xfer(1'b1, 7'h06, 8'ha5);
    xfer(1'b0, 7'h05, 8'h00);
    chk(st[15:8], 8'h5a);
    link(32'h0002_0005);
    axr(REG_PAIR, st, rsp);
    chk(st[15:0], 16'ha55a);
    axr(4'hc, st, rsp);
    chk({st[31:2], rsp}, {30'h0, RESP_SLVERR});
    gauge_wr_addr <= 7'h10;
    gauge_wr_data <= 8'h96;
    gauge_wr_en   <= 1'b1;
    @(posedge aclk);
    gauge_wr_en <= 1'b0;
    xfer(1'b0, 7'h10, 8'h00);
    chk(st[15:8], 8'h96);
    $display("test link done");
    xfer(1'b1, ADDR_NVM_LO, 8'h3c);
    xfer(1'b0, ADDR_NVM_LO, 8'h00);
    chk(st[15:8], 8'h00);
    xfer(1'b1, ADDR_NVM_EN, NVM_EN_KEY);
    chk(nvm_prog_enabled, 1'b1);
    xfer(1'b1, ADDR_NVM_HI, 8'hc3);
    xfer(1'b0, ADDR_NVM_HI, 8'h00);
    chk(st[15:8], 8'hc3);
    prog_pulse <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(nvm_burn, 1'b1);
    prog_pulse <= 1'b0;
    xfer(1'b1, ADDR_NVM_EN, 8'h00);
    chk(nvm_prog_enabled, 1'b0);
    $display("test nvm done");
    supply_ok      <= 1'b0;
    backup_present <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(hibernate, 1'b1);
    supply_ok <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(hibernate, 1'b0);
    xfer(1'b0, 7'h05, 8'h00);
    chk(st[15:8], 8'h5a);
    $display("test hibernate done");
    xfer(1'b1, ADDR_CTRL, CTRL_SHIP);
    chk(ship_armed, 1'b0);
    ship_enable <= 1'b1;
    xfer(1'b1, ADDR_CTRL, CTRL_SHIP);
    chk(ship_armed, 1'b1);
    link(32'h0001_0005);
    chk(ship_armed, 1'b0);
    chk(ship_mode, 1'b0);
    chk(st[15:8], 8'h5a);
    $display("test ship done");
    stop_test();
  end
endmodule
